// file: csp_pkg.sv
package csp_pkg;

    localparam int CLK_MHZ = 100;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] DIV_OFS      = 8'h04;
    localparam logic [7:0] PHASE_OFS    = 8'h08;
    localparam logic [7:0] STATUS_OFS   = 8'h0c;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

    // Register fields: control, divider, status and interrupt.
    localparam int CTRL_FB_LSB     = 0;
    localparam int CTRL_DLY_DYN    = 2;
    localparam int CTRL_PH_DYN     = 3;
    localparam int CTRL_GATE_A     = 4;
    localparam int CTRL_GATE_B     = 5;
    localparam int DIV_FB_LSB      = 0;
    localparam int DIV_OUT_LSB     = 8;
    localparam int STAT_LOCK       = 0;
    localparam int STAT_FROZEN     = 1;
    localparam int STAT_PER_LSB    = 16;
    localparam int IRQ_GAIN        = 0;
    localparam int IRQ_LOSS        = 1;

    // Feedback route encodings.
    localparam logic [1:0] FB_DIRECT_FB_SETTING   = 2'h0;
    localparam logic [1:0] FB_INTERNAL = 2'h1;
    localparam logic [1:0] FB_EXTERNAL = 2'h2;

    // Values after reset, and output divider limits.
    localparam logic [5:0] CTRL_RST   = 6'h00;
    localparam logic [6:0] FB_DIV_RST = 7'h01;
    localparam logic [2:0] OUT_DIV_RST = 3'h1;
    localparam logic [2:0] OUT_DIV_MIN = 3'h1;
    localparam logic [2:0] OUT_DIV_MAX = 3'h6;
    localparam logic [7:0] PHASE_RST  = 8'h00;

    // Settle time before lock is declared, in ns, and in clock cycles (rounded up).
    localparam int LOCK_SETTLE_NS  = 2000;
    localparam int LOCK_SETTLE_CYC = (LOCK_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int REF_TIMEOUT_CYC = 65535;

endpackage

// file: csp_out_div.sv
`timescale 1ns/1ps
`default_nettype none
module csp_out_div
    import csp_pkg::*;
#(
    parameter int DW = 3
)(
    input  wire logic          hclk,
    input  wire logic          rst_n,
    input  wire logic          tick,
    input  wire logic          hold,
    input  wire logic [DW-1:0] div,
    output logic               clk_out
);
    logic [DW-1:0] cnt_r;

    // Counting half-periods of the source keeps a 50 percent duty cycle for odd ratios.
    always_ff @(posedge hclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r   <= '0;
            clk_out <= 1'b0;
        end
        else if (tick && !hold)
        begin
            if (cnt_r + DW'(1) >= div)
            begin
                cnt_r   <= '0;
                clk_out <= ~clk_out;
            end
            else
            begin
                cnt_r <= cnt_r + DW'(1);
            end
        end
    end
endmodule
`default_nettype wire

// file: csp_pll_ctrl.sv
// Functional notes
// - Output frequency is reference times feedback factor over output divider.
// - Each output has own divider, one to six.
// - Lock rises on lock, falls on loss.
// - Phase shift fixed at reset or dynamic.
// - Dynamic phase change drops lock until settled.
// - Direct_fb_setting route: bypass picks reference or synthesized.
// - External feedback used only on external route.
// - Fine delay acts only in dynamic delay mode.
// - Freeze with both gates holds output static.
// - Fabric output matches global output frequency.
// - Outputs feed global network or fabric routing.
`timescale 1ns/1ps
`default_nettype none
module csp_pll_ctrl
    import csp_pkg::*;
#(
    parameter int          PW          = 16,
    parameter logic [15:0] REF_TIMEOUT = 16'(REF_TIMEOUT_CYC),
    parameter int          SETTLE      = LOCK_SETTLE_CYC
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        ref_clk_in,
    input  wire logic        ext_fb_in,
    input  wire logic        bypass_in,
    input  wire logic [3:0]  fine_delay_ctl,
    input  wire logic        freeze_out_req,
    input  wire logic        loop_reset_n,
    output logic             synth_clk_global,
    output logic             synth_clk_fabric,
    output logic             lock_out,
    output logic             irq
);
    localparam int SETTLE_W = $clog2(SETTLE + 1);
    localparam int SETTLE_BOUND = 40;

    // Pin synchronisers: stage one feeds stage two only.
    logic [7:0] pin_s1_r;
    logic [7:0] pin_s2_r;
    logic       ref_d_r;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            ref_d_r  <= 1'b0;
        end
        else
        begin
            pin_s1_r <= {loop_reset_n, freeze_out_req, fine_delay_ctl, bypass_in, ext_fb_in};
            pin_s2_r <= pin_s1_r;
            ref_d_r  <= ref_clk_in;
        end
    end
    // The reference gets its own pair so that edge detection reads only the second stage.
    logic ref_s1_r;
    logic ref_s_r;
    logic ref_p_r;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ref_s1_r <= 1'b0;
            ref_s_r  <= 1'b0;
            ref_p_r  <= 1'b0;
        end
        else
        begin
            ref_s1_r <= ref_d_r;
            ref_s_r  <= ref_s1_r;
            ref_p_r  <= ref_s_r;
        end
    end
    logic ext_p_r;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ext_p_r <= 1'b0;
        else
            ext_p_r <= pin_s2_r[0];
    end

    logic       ext_s;
    logic       bypass_s;
    logic [3:0] fine_s;
    logic       freeze_s;
    logic       loop_rst;
    logic       ref_rise;
    logic       ext_rise;
    assign ext_s    = pin_s2_r[0];
    assign bypass_s = pin_s2_r[1];
    assign fine_s   = pin_s2_r[5:2];
    assign freeze_s = pin_s2_r[6];
    assign loop_rst = !pin_s2_r[7];
    assign ref_rise = ref_s_r && !ref_p_r;
    assign ext_rise = ext_s && !ext_p_r;

    // Bus slave: zero wait states, always OKAY.
    logic [5:0]  ctrl_r;
    logic [6:0]  fb_div_r;
    logic [2:0]  out_div_r;
    logic [7:0]  phase_r;
    logic [1:0]  irq_stat_r;
    logic [1:0]  irq_mask_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic        lock_r;
    logic        frozen;
    logic [PW-1:0] period_r;
    logic        acc_phase;
    logic        rd_acc;
    logic [7:0]  a_ofs;
    logic        ph_wr;
    logic [2:0]  out_div_nxt;

    assign acc_phase = hsel && hready && htrans[1];
    assign rd_acc    = acc_phase && !hwrite;
    assign a_ofs     = haddr[7:0];
    assign ph_wr     = wr_pend_r && (wr_addr_r == PHASE_OFS);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            wr_pend_r <= acc_phase && hwrite && (haddr[31:8] == 24'h000000);
            wr_addr_r <= a_ofs;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_comb
    begin
        out_div_nxt = hwdata[DIV_OUT_LSB +: 3];
        if (out_div_nxt < OUT_DIV_MIN)
            out_div_nxt = OUT_DIV_MIN;
        else if (out_div_nxt > OUT_DIV_MAX)
            out_div_nxt = OUT_DIV_MAX;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_r     <= CTRL_RST;
            fb_div_r   <= FB_DIV_RST;
            out_div_r  <= OUT_DIV_RST;
            phase_r    <= PHASE_RST;
            irq_mask_r <= 2'h0;
        end
        else if (wr_pend_r)
        begin
            unique case (wr_addr_r)
                CTRL_OFS:     ctrl_r     <= hwdata[5:0];
                DIV_OFS:
                begin
                    fb_div_r  <= (hwdata[6:0] == 7'h00) ? 7'h01 : hwdata[6:0];
                    out_div_r <= out_div_nxt;
                end
                PHASE_OFS:    phase_r    <= hwdata[7:0];
                IRQ_MASK_OFS: irq_mask_r <= hwdata[1:0];
                default:      ;
            endcase
        end
    end

    // Reads are sampled in the address phase, so a read right behind a write to the
    // same register returns the old value.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (rd_acc)
        begin
            hrdata <= 32'h00000000;
            if (haddr[31:8] == 24'h000000)
            begin
                unique case (a_ofs)
                    CTRL_OFS:     hrdata <= {26'h0000000, ctrl_r};
                    DIV_OFS:      hrdata <= {21'h000000, out_div_r, 1'b0, fb_div_r};
                    PHASE_OFS:    hrdata <= {24'h000000, phase_r};
                    STATUS_OFS:   hrdata <= {period_r, 14'h0000, frozen, lock_r};
                    IRQ_STAT_OFS: hrdata <= {30'h00000000, irq_stat_r};
                    IRQ_MASK_OFS: hrdata <= {30'h00000000, irq_mask_r};
                    default:      hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    logic [1:0] fb_sel;
    logic       ext_sel;
    logic       dly_dyn;
    logic       ph_dyn;
    assign fb_sel  = ctrl_r[CTRL_FB_LSB +: 2];
    assign ext_sel = (fb_sel == FB_EXTERNAL);
    assign dly_dyn = ctrl_r[CTRL_DLY_DYN];
    assign ph_dyn  = ctrl_r[CTRL_PH_DYN];
    assign frozen  = freeze_s && ctrl_r[CTRL_GATE_A] && ctrl_r[CTRL_GATE_B];

    // Fixed phase is taken only while the loop is in reset, as at configuration time.
    logic [7:0] phase_fix_r;
    logic [7:0] phase_eff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            phase_fix_r <= PHASE_RST;
        else if (loop_rst)
            phase_fix_r <= phase_r;
    end
    assign phase_eff = ph_dyn ? phase_r : phase_fix_r;

    // Reference period measurement.
    logic [PW-1:0] per_cnt_r;
    logic [PW-1:0] per_prev_r;
    logic          ref_lost;
    assign ref_lost = (per_cnt_r >= REF_TIMEOUT);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            per_cnt_r  <= '0;
            period_r   <= '0;
            per_prev_r <= '0;
        end
        else if (loop_rst)
        begin
            per_cnt_r <= '0;
            period_r  <= '0;
        end
        else if (ref_rise)
        begin
            per_cnt_r  <= PW'(1);
            per_prev_r <= period_r;
            period_r   <= per_cnt_r;
        end
        else if (!ref_lost)
            per_cnt_r <= per_cnt_r + PW'(1);
    end

    // Digital oscillator: 2*fb_div toggles per reference period, realigned at each reference edge.
    logic [PW+1:0] acc_r;
    logic          vco_r;
    logic          vco_tick;
    logic [PW+1:0] inc;
    assign inc      = (PW+2)'({fb_div_r, 1'b0});
    assign vco_tick = !frozen && (period_r != '0) && (acc_r + inc >= (PW+2)'(period_r));
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc_r <= '0;
            vco_r <= 1'b0;
        end
        else if (loop_rst)
        begin
            acc_r <= '0;
            vco_r <= 1'b0;
        end
        else if (frozen)
            acc_r <= acc_r;
        else if (ref_rise)
        begin
            acc_r <= (PW+2)'(phase_eff);
            vco_r <= 1'b0;
        end
        else if (vco_tick)
        begin
            acc_r <= acc_r + inc - (PW+2)'(period_r);
            vco_r <= ~vco_r;
        end
        else
            acc_r <= acc_r + inc;
    end

    // Feedback count per reference period; the external pin is ignored on other routes.
    logic       fb_edge;
    logic [7:0] fb_cnt_r;
    logic [7:0] fb_last_r;
    logic [7:0] fb_exp;
    assign fb_edge = ext_sel ? ext_rise : (vco_tick && !vco_r);
    assign fb_exp  = ext_sel ? 8'h01 : {1'b0, fb_div_r};
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fb_cnt_r  <= 8'h00;
            fb_last_r <= 8'h00;
        end
        else if (ref_rise)
        begin
            fb_cnt_r  <= 8'h00;
            fb_last_r <= fb_cnt_r;
        end
        else if (fb_edge && fb_cnt_r != 8'hff)
            fb_cnt_r <= fb_cnt_r + 8'h01;
    end

    // Lock detection with settle counter.
    logic                per_ok;
    logic                fb_ok;
    logic                bad;
    logic [SETTLE_W-1:0] settle_r;
    assign per_ok = (period_r != '0) && (period_r + PW'(1) >= per_prev_r) && (period_r <= per_prev_r + PW'(1));
    assign fb_ok  = (fb_last_r + 8'h01 >= fb_exp) && (fb_last_r <= fb_exp + 8'h01);
    assign bad    = ref_lost || (ref_rise && !(per_ok && fb_ok)) || (ph_wr && ph_dyn);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            settle_r <= '0;
            lock_r   <= 1'b0;
        end
        else if (loop_rst)
        begin
            settle_r <= '0;
            lock_r   <= 1'b0;
        end
        else if (bad)
        begin
            settle_r <= '0;
            lock_r   <= 1'b0;
        end
        else if (settle_r == SETTLE_W'(SETTLE))
            lock_r <= 1'b1;
        else
            settle_r <= settle_r + SETTLE_W'(1);
    end

    // Fine delay line, tapped only in dynamic delay mode.
    logic [15:0] dly_r;
    logic        dly_tap;
    logic        dly_p_r;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dly_r   <= 16'h0000;
            dly_p_r <= 1'b0;
        end
        else
        begin
            dly_r   <= {dly_r[14:0], vco_r};
            dly_p_r <= dly_tap;
        end
    end
    assign dly_tap = dly_dyn ? dly_r[fine_s] : vco_r;

    // One divider per output, both loaded from the same ratio so their frequencies agree.
    logic [1:0] div_out;
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_div
            csp_out_div #(
                .DW      (3)
            ) u_div (
                .hclk    (hclk),
                .rst_n   (hresetn),
                .tick    (dly_tap != dly_p_r),
                .hold    (frozen),
                .div     (out_div_r),
                .clk_out (div_out[g])
            );
        end
    endgenerate

    logic bypass_sel;
    assign bypass_sel = (fb_sel == FB_DIRECT_FB_SETTING) && bypass_s;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            synth_clk_global <= 1'b0;
            synth_clk_fabric <= 1'b0;
        end
        else if (!frozen)
        begin
            synth_clk_global <= bypass_sel ? ref_s_r : div_out[0];
            synth_clk_fabric <= bypass_sel ? ref_s_r : div_out[1];
        end
    end

    // Interrupts: set wins over the clear by read.
    logic [1:0] irq_set;
    logic       lock_p_r;
    logic       stat_rd;
    assign stat_rd = rd_acc && (haddr[31:8] == 24'h000000) && (a_ofs == IRQ_STAT_OFS);
    assign irq_set = {lock_p_r && !lock_r, !lock_p_r && lock_r};
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lock_p_r   <= 1'b0;
            irq_stat_r <= 2'h0;
            irq        <= 1'b0;
            lock_out   <= 1'b0;
        end
        else
        begin
            lock_p_r   <= lock_r;
            irq_stat_r <= (irq_stat_r & ~{2{stat_rd}}) | irq_set;
            irq        <= |(irq_stat_r & irq_mask_r);
            lock_out   <= lock_r;
        end
    end

    sequence s_dyn_ph_wr;
        ph_wr && ph_dyn;
    endsequence
    sequence s_unlocked;
        !lock_r [*2];
    endsequence

    a_reset_unlock: assert property (@(posedge hclk) disable iff (!hresetn)
        loop_rst |=> !lock_r ##1 !lock_out)
        else $error("lock seen while loop reset held");
    a_phase_unlock: assert property (@(posedge hclk) disable iff (!hresetn)
        s_dyn_ph_wr |=> s_unlocked)
        else $error("lock kept after dynamic phase change");
    a_lock_settled: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(lock_r) |-> $past(settle_r) == SETTLE_W'(SETTLE) && !$past(bad))
        else $error("lock rose before settle time");
    a_lock_loss: assert property (@(posedge hclk) disable iff (!hresetn)
        lock_r && bad && !loop_rst |=> !lock_r ##[1:SETTLE_BOUND] 1'b1)
        else $error("lock not dropped on loss");
    a_bypass_ref: assert property (@(posedge hclk) disable iff (!hresetn)
        bypass_sel && !frozen |=> synth_clk_global == $past(ref_s_r))
        else $error("bypass did not pass reference");
    a_freeze_static: assert property (@(posedge hclk) disable iff (!hresetn)
        frozen |=> $stable(synth_clk_global) && $stable(synth_clk_fabric))
        else $error("output moved while frozen");
    a_out_match: assert property (@(posedge hclk) disable iff (!hresetn)
        div_out[0] == div_out[1])
        else $error("fabric and global dividers differ");
    a_div_range: assert property (@(posedge hclk) disable iff (!hresetn)
        out_div_r >= OUT_DIV_MIN && out_div_r <= OUT_DIV_MAX)
        else $error("output divider out of range");
    a_ext_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
        !ext_sel && ext_rise && !vco_tick && !ref_rise |=> $stable(fb_cnt_r))
        else $error("external feedback counted on internal route");
    a_fine_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
        !dly_dyn |-> dly_tap == vco_r)
        else $error("fine delay applied in fixed mode");
    a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 irq == |($past(irq_stat_r) & $past(irq_mask_r)))
        else $error("interrupt level mismatch");
endmodule
`default_nettype wire

// file: csp_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
module csp_fabric_model (
    input  wire logic       hclk,
    input  wire logic [7:0] half_per,
    output logic            ref_clk_in,
    output logic            ext_fb_in
);
    logic [7:0] cnt_r;
    logic       fb_dly_r;

    initial
    begin
        cnt_r = 8'h00;
        ref_clk_in = 1'b0;
        fb_dly_r = 1'b0;
        ext_fb_in = 1'b0;
    end

    // A zero half period parks the reference low, as a dead oscillator would.
    always @(posedge hclk)
    begin
        if (half_per != 8'h00)
        begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r + 8'h01 >= half_per)
            begin
                cnt_r <= 8'h00;
                ref_clk_in <= ~ref_clk_in;
            end
        end
        else
            ref_clk_in <= 1'b0;
    end

    // The board trace returns the reference two cycles late: one edge per period.
    always @(posedge hclk)
    begin
        fb_dly_r <= ref_clk_in;
        ext_fb_in <= fb_dly_r;
    end
endmodule
`default_nettype wire

// file: clock_synth_pll_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module clock_synth_pll_control_bench;
    import csp_pkg::*;
    localparam int SETTLE = 8;
    typedef struct {logic [5:0] ctrl; logic [31:0] div; logic byp; int rises;} csp_row_t;
    logic        hclk = 0, hresetn = 0, hwrite = 0, bypass_in = 0, freeze_out_req = 0, loop_reset_n = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0]  htrans = 0;
    logic [7:0]  half_per = 8'h14;
    logic [3:0]  fine_delay_ctl = 4'h5;
    logic        hreadyout, hresp, ref_clk_in, ext_fb_in, synth_clk_global, synth_clk_fabric, lock_out, irq;
    int          error_cnt = 0, checked = 0, ng, nf;
    csp_row_t    rows[6];

    always #5 hclk = ~hclk;

    csp_pll_ctrl #(.REF_TIMEOUT(16'h00c8), .SETTLE(SETTLE)) u_csp_pll_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .ref_clk_in(ref_clk_in), .ext_fb_in(ext_fb_in), .bypass_in(bypass_in),
        .fine_delay_ctl(fine_delay_ctl), .freeze_out_req(freeze_out_req), .loop_reset_n(loop_reset_n),
        .synth_clk_global(synth_clk_global), .synth_clk_fabric(synth_clk_fabric), .lock_out(lock_out),
        .irq(irq));
    csp_fabric_model u_csp_fabric_model (.hclk(hclk), .half_per(half_per), .ref_clk_in(ref_clk_in),
        .ext_fb_in(ext_fb_in));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi, input string what);
        checked++;
        if (got < lo || got > hi)
        begin
            error_cnt++;
            $display("[ERR] %0t %s count %0d outside %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    // Every wait is bounded so a stuck handshake ends the run instead of hanging it.
    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            error_cnt++;
            $display("[ERR] %0t bus ready timeout", $time);
            conclude();
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask

    task automatic wait_lock(input logic lvl, input int bound);
        int n;
        n = 0;
        while (lock_out !== lvl && n < bound)
        begin
            @(negedge hclk);
            n++;
        end
        if (lock_out !== lvl)
        begin
            error_cnt++;
            $display("[ERR] %0t lock did not reach %b", $time, lvl);
            conclude();
        end
    endtask

    task automatic count_rises(input int cyc);
        logic pg, pf;
        ng = 0;
        nf = 0;
        @(negedge hclk);
        pg = synth_clk_global;
        pf = synth_clk_fabric;
        repeat (cyc)
        begin
            @(negedge hclk);
            ng += int'(synth_clk_global & ~pg);
            nf += int'(synth_clk_fabric & ~pf);
            pg = synth_clk_global;
            pf = synth_clk_fabric;
        end
    endtask

    initial
    begin
        // Reference period is 40 cycles; counts below cover 8 periods.
        rows[0] = '{{4'h0, FB_INTERNAL}, 32'h0102, 1'b0, 16};
        rows[1] = '{{4'h0, FB_INTERNAL}, 32'h0606, 1'b0, 8};
        rows[2] = '{{4'h0, FB_INTERNAL}, 32'h0204, 1'b0, 16};
        rows[3] = '{{4'h0, FB_DIRECT_FB_SETTING}, 32'h0102, 1'b1, 8};
        rows[4] = '{{4'h0, FB_DIRECT_FB_SETTING}, 32'h0103, 1'b0, 24};
        rows[5] = '{{4'h1, FB_EXTERNAL}, 32'h0101, 1'b0, 8};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        chk({26'h0, hreadyout, hresp, synth_clk_global, synth_clk_fabric, lock_out, irq}, 32'h20, "outputs at reset");
        ahb(0, CTRL_OFS, 0);
        chk(q, 32'h0, "ctrl reset");
        ahb(0, DIV_OFS, 0);
        chk(q, 32'h0101, "div reset");
        ahb(0, PHASE_OFS, 0);
        chk(q, 32'h0, "phase reset");
        $display("test reset done");
        ahb(1, IRQ_MASK_OFS, 32'h3);
        foreach (rows[i])
        begin
            ahb(1, DIV_OFS, rows[i].div);
            bypass_in <= rows[i].byp;
            ahb(1, CTRL_OFS, {26'h0, rows[i].ctrl});
            repeat (100) @(posedge hclk);
            wait_lock(1'b1, 3000);
            repeat (40) @(posedge hclk);
            count_rises(320);
            chk_rng(ng, rows[i].rises - 1, rows[i].rises + 1, "global rate");
            chk_rng(nf, ng - 1, ng + 1, "fabric rate");
            $display("test row %0d done", i);
        end
        ahb(1, PHASE_OFS, 32'ha5);
        ahb(0, PHASE_OFS, 0);
        chk(q, 32'ha5, "phase rw");
        ahb(1, 8'h40, 32'h1234);
        ahb(0, 8'h40, 0);
        chk(q, 32'h0, "unmapped");
        chk({31'h0, hresp}, 32'h0, "okay response");
        ahb(0, STATUS_OFS, 0);
        chk(q & 32'hffff0003, 32'h00280001, "status period lock");
        $display("test registers done");
        ahb(1, DIV_OFS, 32'h0102);
        ahb(1, CTRL_OFS, 32'h11);
        freeze_out_req <= 1'b1;
        repeat (100) @(posedge hclk);
        count_rises(160);
        chk_rng(ng, 7, 9, "one gate only");
        ahb(1, CTRL_OFS, 32'h31);
        repeat (10) @(posedge hclk);
        count_rises(160);
        chk_rng(ng + nf, 0, 0, "frozen outputs");
        ahb(0, STATUS_OFS, 0);
        chk(q & 32'h2, 32'h2, "frozen flag");
        freeze_out_req <= 1'b0;
        $display("test freeze done");
        // A phase beyond the reference period would upset the feedback count, so start from zero.
        ahb(1, PHASE_OFS, 32'h0);
        ahb(1, CTRL_OFS, 32'h09);
        wait_lock(1'b1, 3000);
        ahb(0, IRQ_STAT_OFS, 0);
        ahb(1, IRQ_MASK_OFS, 32'h1);
        ahb(1, PHASE_OFS, 32'h10);
        wait_lock(1'b0, 20);
        repeat (SETTLE - 2) @(negedge hclk);
        chk({30'h0, lock_out, irq}, 32'h0, "unlocked and masked");
        ahb(1, IRQ_MASK_OFS, 32'h2);
        repeat (3) @(negedge hclk);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        ahb(0, IRQ_STAT_OFS, 0);
        chk(q & 32'h2, 32'h2, "loss event");
        repeat (3) @(negedge hclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        $display("test phase done");
        wait_lock(1'b1, 3000);
        @(posedge hclk);
        loop_reset_n <= 1'b0;
        wait_lock(1'b0, 8);
        repeat (20) @(negedge hclk);
        chk({31'h0, lock_out}, 32'h0, "held in loop reset");
        @(posedge hclk);
        loop_reset_n <= 1'b1;
        wait_lock(1'b1, 3000);
        $display("test loop reset done");
        @(posedge hclk);
        half_per <= 8'h00;
        wait_lock(1'b0, 400);
        chk({31'h0, lock_out}, 32'h0, "reference lost");
        $display("test ref stop done");
        conclude();
    end
endmodule
`default_nettype wire
